// ### core/metering_cfg.svh
// Offsets, field positions, reset values and timing counts of the configuration register
`ifndef METERING_CFG_SVH
`define METERING_CFG_SVH

`define ADDR_W 16
`define DATA_W 16
`define SAMPLE_W 24

`define CFG_ADDR 16'he618
`define CFG_RESET 16'h0000
`define CFG_WMASK 16'h3ff9
`define RDATA_NONE 16'h0000

`define BIT_INTEG 0
`define BIT_SWAP 3
`define BIT_VGND 4
`define BIT_IGND 5
`define BIT_FAST 6
`define BIT_SRST 7
`define SEL_A_LSB 8
`define SEL_B_LSB 10
`define SEL_C_LSB 12
`define SEL_W 2
`define SEL_MIRROR 2'h3

`define CLOCK_MHZ 125
`define SRST_NS 64
`define SRST_CYCLES ((`SRST_NS * `CLOCK_MHZ + 999) / 1000)
`define SRST_CNT_W 4

`endif

// ### core/metering_pkg.sv
// Types shared by the configuration register and its users
`include "metering_cfg.svh"

package metering_pkg;

	typedef logic signed [`SAMPLE_W-1:0] sample_t;

	typedef enum logic [1:0] {
		PH_A = 2'h0,
		PH_B = 2'h1,
		PH_C = 2'h2
	} phase_e;

	typedef struct packed {
		sample_t va;
		sample_t vb;
		sample_t vc;
		sample_t ia;
		sample_t ib;
		sample_t ic;
		sample_t in;
	} adc_s;

	typedef struct packed {
		sample_t a;
		sample_t b;
		sample_t c;
	} tri_s;

	typedef struct packed {
		logic integrator_enable;
		logic channel_swap;
		logic voltage_adc_ground;
		logic current_adc_ground;
		logic fast_port_enable;
		phase_e phase_a_voltage_select;
		phase_e phase_b_voltage_select;
		phase_e phase_c_voltage_select;
	} ctrl_s;

endpackage

// ### core/metering_config_register.sv
// Configuration register of the polyphase metering core with its channel steering
`timescale 1ns/1ps
`default_nettype none
`include "metering_cfg.svh"

// How it works
// - Bit 0 enables integrator on all currents
// - Bit 3 swaps voltage and current channel outputs
// - Bit 4 forces voltage ADC outputs to zero
// - Bit 5 forces current ADC outputs to zero
// - Bit 6 enables fast port, pin carries clock
// - Bit 6 clear: port off, pin carries pulse
// - Writing 1 to bit 7 starts soft reset
// - Bits 9:8 pick voltage for phase A
// - Phase A select value 3 acts as 0
// - Bits 11:10 pick voltage for phase B
// - Phase B select value 3 acts as 0
// - Bits 13:12 pick voltage for phase C
// - Phase C select value 3 acts as 0
// - Reserved bits never affect any function
module metering_config_register
	import metering_pkg::*;
#(
	parameter int SRST_CYCLES = `SRST_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`DATA_W-1:0] reg_rdata,
	output ctrl_s ctrl,
	output logic soft_reset,
	output logic config_written,
	input wire adc_s adc_in,
	input wire logic adc_valid,
	output adc_s chan_out,
	output logic chan_valid,
	output tri_s power_voltage,
	output tri_s power_current,
	output logic power_valid,
	input wire logic third_pulse_output,
	input wire logic fast_port_clock,
	output logic shared_pin
);

	// One-hot so a single upset lands in the recovery branch
	typedef enum logic [1:0] {
		SRST_IDLE = 2'b01,
		SRST_HOLD = 2'b10
	} srst_e;

	typedef struct packed {
		logic [`DATA_W-1:0] cfg;
		logic [`DATA_W-1:0] rdata;
		ctrl_s ctrl;
		logic [`SRST_CNT_W-1:0] srst_cnt;
		logic srst;
		logic written;
		adc_s chan;
		logic chan_valid;
		tri_s pv;
		tri_s pi;
		logic power_valid;
		logic pin;
		srst_e srst_state;
	} state_s;

	state_s s_q;
	state_s s_d;

	// Values 0 and 3 select the phase's own voltage; 1 and 2 rotate A, B, C
	function automatic phase_e pair_phase(
		input logic [`SEL_W-1:0] field,
		input phase_e own
	);
		phase_e next_ph;
		phase_e prev_ph;
		case (own)
			PH_B: begin
				next_ph = PH_C;
				prev_ph = PH_A;
			end
			PH_C: begin
				next_ph = PH_A;
				prev_ph = PH_B;
			end
			default: begin
				next_ph = PH_B;
				prev_ph = PH_C;
			end
		endcase
		case (field)
			2'h1: pair_phase = next_ph;
			2'h2: pair_phase = prev_ph;
			`SEL_MIRROR: pair_phase = own;
			default: pair_phase = own;
		endcase
	endfunction

	function automatic sample_t pick_voltage(
		input phase_e p,
		input adc_s x
	);
		case (p)
			PH_A: pick_voltage = x.va;
			PH_B: pick_voltage = x.vb;
			PH_C: pick_voltage = x.vc;
			default: pick_voltage = x.va;
		endcase
	endfunction

	function automatic logic [`SEL_W-1:0] sel_field(
		input logic [`DATA_W-1:0] cfg,
		input int lsb
	);
		sel_field = cfg[lsb +: `SEL_W];
	endfunction

	// Full address compare; the register has no alias in the map
	function automatic logic cfg_hit(
		input logic [`ADDR_W-1:0] addr
	);
		if (addr == `CFG_ADDR) begin
			cfg_hit = 1'b1;
		end else begin
			cfg_hit = 1'b0;
		end
	endfunction

	// Other addresses read zero rather than stale data
	function automatic logic [`DATA_W-1:0] read_word(
		input logic [`ADDR_W-1:0] addr,
		input logic [`DATA_W-1:0] cfg
	);
		if (cfg_hit(addr)) begin
			read_word = cfg;
		end else begin
			read_word = `RDATA_NONE;
		end
	endfunction

	// Reserved bits are dropped on entry so they read back as zero
	function automatic logic [`DATA_W-1:0] write_image(
		input logic [`DATA_W-1:0] wdata
	);
		write_image = wdata & `CFG_WMASK;
	endfunction

	function automatic ctrl_s decode_ctrl(
		input logic [`DATA_W-1:0] cfg
	);
		ctrl_s c;
		c.integrator_enable = cfg[`BIT_INTEG];
		c.channel_swap = cfg[`BIT_SWAP];
		c.voltage_adc_ground = cfg[`BIT_VGND];
		c.current_adc_ground = cfg[`BIT_IGND];
		c.fast_port_enable = cfg[`BIT_FAST];
		c.phase_a_voltage_select =
			pair_phase(sel_field(cfg, `SEL_A_LSB), PH_A);
		c.phase_b_voltage_select =
			pair_phase(sel_field(cfg, `SEL_B_LSB), PH_B);
		c.phase_c_voltage_select =
			pair_phase(sel_field(cfg, `SEL_C_LSB), PH_C);
		decode_ctrl = c;
	endfunction

	// Grounding comes before the swap, so bits 4 and 5 name the inputs
	function automatic adc_s ground_samples(
		input adc_s x,
		input ctrl_s c
	);
		adc_s g;
		g = x;
		if (c.voltage_adc_ground) begin
			g.va = '0;
			g.vb = '0;
			g.vc = '0;
		end
		if (c.current_adc_ground) begin
			g.ia = '0;
			g.ib = '0;
			g.ic = '0;
			g.in = '0;
		end
		ground_samples = g;
	endfunction

	// Neutral has no voltage partner, so it never moves
	function automatic adc_s route_channels(
		input adc_s g,
		input logic swap
	);
		adc_s r;
		r = g;
		if (swap) begin
			r.va = g.ia;
			r.vb = g.ib;
			r.vc = g.ic;
			r.ia = g.va;
			r.ib = g.vb;
			r.ic = g.vc;
		end
		route_channels = r;
	endfunction

	// Pairing reads the grounded samples, unswapped
	function automatic tri_s pair_voltages(
		input ctrl_s c,
		input adc_s g
	);
		tri_s v;
		v.a = pick_voltage(c.phase_a_voltage_select, g);
		v.b = pick_voltage(c.phase_b_voltage_select, g);
		v.c = pick_voltage(c.phase_c_voltage_select, g);
		pair_voltages = v;
	endfunction

	// Currents reach the power path unswapped
	function automatic tri_s phase_currents(
		input adc_s g
	);
		tri_s i;
		i.a = g.ia;
		i.b = g.ib;
		i.c = g.ic;
		phase_currents = i;
	endfunction

	function automatic logic pin_source(
		input logic fast_on,
		input logic port_clock,
		input logic pulse
	);
		if (fast_on) begin
			pin_source = port_clock;
		end else begin
			pin_source = pulse;
		end
	endfunction

	always_comb begin
		adc_s g;
		logic [`DATA_W-1:0] cfg_next;
		logic start_srst;
		g = ground_samples(adc_in, s_q.ctrl);
		cfg_next = s_q.cfg;
		start_srst = reg_write && cfg_hit(reg_addr) && reg_wdata[`BIT_SRST];
		s_d = s_q;

		// Register port
		s_d.rdata = `RDATA_NONE;
		s_d.written = 1'b0;
		if (reg_read) begin
			s_d.rdata = read_word(reg_addr, s_q.cfg);
		end
		if (reg_write && cfg_hit(reg_addr)) begin
			cfg_next = write_image(reg_wdata);
			s_d.written = 1'b1;
		end
		s_d.cfg = cfg_next;

		// Decoded controls follow the stored image one cycle later at most
		s_d.ctrl = decode_ctrl(cfg_next);

		// Soft reset: a write of 1 restarts the stretch, even if already running
		s_d.srst_cnt = s_q.srst_cnt;
		s_d.srst = 1'b0;
		case (s_q.srst_state)
			SRST_IDLE: begin
				s_d.srst_cnt = '0;
				if (start_srst) begin
					s_d.srst_cnt = SRST_CYCLES[`SRST_CNT_W-1:0];
					s_d.srst = 1'b1;
					s_d.srst_state = SRST_HOLD;
				end
			end
			SRST_HOLD: begin
				s_d.srst = 1'b1;
				if (start_srst) begin
					s_d.srst_cnt = SRST_CYCLES[`SRST_CNT_W-1:0];
				end else if (s_q.srst_cnt > `SRST_CNT_W'(1)) begin
					s_d.srst_cnt = s_q.srst_cnt - `SRST_CNT_W'(1);
				end else begin
					s_d.srst_cnt = '0;
					s_d.srst = 1'b0;
					s_d.srst_state = SRST_IDLE;
				end
			end
			default: begin
				s_d.srst_cnt = '0;
				s_d.srst_state = SRST_IDLE;
			end
		endcase

		// Shared pin: clock of the fast port or the third pulse output
		s_d.pin = pin_source(s_q.ctrl.fast_port_enable, fast_port_clock,
			third_pulse_output);

		// Channel registers and power path only move on a sample strobe
		s_d.chan_valid = adc_valid;
		s_d.power_valid = adc_valid;
		if (adc_valid) begin
			s_d.chan = route_channels(g, s_q.ctrl.channel_swap);
			s_d.pv = pair_voltages(s_q.ctrl, g);
			s_d.pi = phase_currents(g);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// Each field spelled out so its reset value is visible
			s_q.cfg <= `CFG_RESET;
			s_q.rdata <= `RDATA_NONE;
			s_q.ctrl <= '0;
			s_q.srst_cnt <= '0;
			s_q.srst <= 1'b0;
			s_q.written <= 1'b0;
			s_q.chan <= '0;
			s_q.chan_valid <= 1'b0;
			s_q.pv <= '0;
			s_q.pi <= '0;
			s_q.power_valid <= 1'b0;
			s_q.pin <= 1'b0;
			s_q.srst_state <= SRST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output is a flip-flop
	assign reg_rdata = s_q.rdata;
	assign ctrl = s_q.ctrl;
	assign soft_reset = s_q.srst;
	assign config_written = s_q.written;
	assign chan_out = s_q.chan;
	assign chan_valid = s_q.chan_valid;
	assign power_voltage = s_q.pv;
	assign power_current = s_q.pi;
	assign power_valid = s_q.power_valid;
	assign shared_pin = s_q.pin;

endmodule
`default_nettype wire

// ### verif/cfg_sva.sv
// Port checker for the configuration register
`timescale 1ns/1ps
`default_nettype none
`include "metering_cfg.svh"
module cfg_sva
	import metering_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire ctrl_s ctrl,
	input wire logic soft_reset,
	input wire logic adc_valid,
	input wire tri_s power_voltage,
	input wire tri_s power_current,
	input wire logic third_pulse_output,
	input wire logic fast_port_clock,
	input wire logic shared_pin
);
	wire logic w = reg_write && reg_addr == `CFG_ADDR;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	a_volt_ground:
	assert property (adc_valid && ctrl.voltage_adc_ground |=> power_voltage == '0) else $error("vg");
	a_curr_ground:
	assert property (adc_valid && ctrl.current_adc_ground |=> power_current == '0) else $error("ig");
	// Reset edge excluded: pin is cleared then, not routed
	a_pin_fast:
	assert property (!$past(rst) && $past(ctrl.fast_port_enable) |-> shared_pin == $past(
		fast_port_clock)) else $error("pf");
	a_pin_pulse:
	assert property (!$past(rst) && !$past(ctrl.fast_port_enable) |-> shared_pin == $past(
		third_pulse_output)) else $error("pp");
	a_srst_start:
	assert property (w && reg_wdata[7] |=> soft_reset) else $error("sr");
	// Field value 3 wraps to the own phase through the modulo
	a_sel_a:
	assert property (w |=> ctrl.phase_a_voltage_select == phase_e'($past(reg_wdata[9:8]) % 3))
		else $error("sa");
	a_sel_b:
	assert property (w |=> ctrl.phase_b_voltage_select == phase_e'(($past(reg_wdata[11:10]) + 1)
		% 3)) else $error("sb");
	a_sel_c:
	assert property (w |=> ctrl.phase_c_voltage_select == phase_e'(($past(reg_wdata[13:12]) + 2)
		% 3)) else $error("sc");
	a_integ_bit:
	assert property (w |=> ctrl.integrator_enable == $past(reg_wdata[0])) else $error("ie");
	c_srst: cover property (w && reg_wdata[7]);
	c_fast: cover property (ctrl.fast_port_enable ##1 shared_pin);
	c_gnd: cover property (adc_valid && ctrl.voltage_adc_ground);
endmodule
bind metering_config_register cfg_sva cfg_sva_i (.*);
`default_nettype wire

// ### verif/metering_config_register_tb_top.sv
// Self-checking bench for the configuration register
`timescale 1ns/1ps
`default_nettype none
`include "metering_cfg.svh"
module metering_config_register_tb_top
	import metering_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	// Sampling every cycle keeps the power path tracking ctrl
	logic adc_valid = 1'b1;
	logic third_pulse_output = 1'b0;
	logic fast_port_clock = 1'b1;
	adc_s adc_in = '{24'h1, 24'h2, 24'h3, 24'h4, 24'h5, 24'h6, 24'h7};
	logic [15:0] reg_rdata;
	ctrl_s ctrl;
	adc_s chan_out;
	tri_s power_voltage, power_current;
	logic soft_reset, config_written, chan_valid, power_valid, shared_pin;
	int failures = 0;
	int n_tests = 0;
	metering_config_register #(.SRST_CYCLES(2)) metering_config_register_i (.*);
	always #4 clock = ~clock;
	task automatic chk(string n, logic [71:0] e, logic [71:0] s);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic acc(logic r, logic [15:0] a, logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= !r;
		reg_read <= r;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
		// Outputs launched by the taking edge are settled at the falling edge
		@(negedge clock);
		chk("written", !r, config_written);
		if (r)
			chk("rdata", d, reg_rdata);
	endtask
	task automatic test_done;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		acc(1, `CFG_ADDR, 16'h0000);
		acc(0, `CFG_ADDR, 16'hffff);
		chk("srst", 1, soft_reset);
		@(negedge clock);
		chk("srst", 1, soft_reset);
		@(negedge clock);
		chk("srst", 0, soft_reset);
		acc(1, `CFG_ADDR, 16'h3ff9);
		acc(1, 16'h0000, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			acc(0, `CFG_ADDR, 16'(k * 'h1500 + k % 2));
			chk("integ", k % 2, ctrl.integrator_enable);
			@(negedge clock);
			chk("sel_a", k % 3 + 1, power_voltage.a);
			chk("sel_b", (k + 1) % 3 + 1, power_voltage.b);
			chk("sel_c", (k + 2) % 3 + 1, power_voltage.c);
		end
		acc(0, `CFG_ADDR, 16'h0030);
		@(negedge clock);
		chk("vgnd", 0, power_voltage);
		chk("ignd", 0, power_current);
		chk("ignd_n", 0, chan_out.in);
		acc(0, `CFG_ADDR, 16'h0008);
		@(negedge clock);
		chk("swap", 48'h000004_000001, {chan_out.va, chan_out.ia});
		chk("pcur", {24'h4, 24'h5, 24'h6}, power_current);
		chk("valid", 2'b11, {chan_valid, power_valid});
		acc(0, `CFG_ADDR, 16'hc006);
		chk("rsvd", 11'h006, ctrl);
		acc(1, `CFG_ADDR, 16'h0000);
		acc(0, `CFG_ADDR, 16'h0040);
		@(negedge clock);
		chk("pin", 1, shared_pin);
		@(posedge clock);
		fast_port_clock <= 1'b0;
		third_pulse_output <= 1'b1;
		acc(0, `CFG_ADDR, 16'h0000);
		@(negedge clock);
		chk("pin", 1, shared_pin);
		acc(0, `CFG_ADDR, 16'h1234);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		acc(1, `CFG_ADDR, 16'h0000);
		chk("ctrl_rst", 11'h006, ctrl);
		test_done;
	end
endmodule
`default_nettype wire
